//--- csd_decoder.sv
`timescale 1ns/1ns
module csd_decoder
  import csd_pkg::*;
#(
  parameter logic [7:0] DEV_ID = 8'h5A // Arbitrary identifier value
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic frame_start_i,
  input wire logic frame_end_i,
  input wire logic rx_valid_i,
  input wire logic [15:0] rx_word_i,
  input wire logic [7:0] fault_status_i,
  output logic [31:0] tx_status_o,
  output logic one_word_frame_o,
  output logic [7:0] extra_words_o,
  output logic standby_o,
  output logic locked_o
);

  // ---------------------------------------------------------------
  // Frame capture interface and instance
  // ---------------------------------------------------------------
  csd_frame_if fr ();

  csd_frame_capture u_cap (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .frame_start_i(frame_start_i),
    .frame_end_i(frame_end_i),
    .rx_valid_i(rx_valid_i),
    .rx_word_i(rx_word_i),
    .fr(fr)
  );

  // ---------------------------------------------------------------
  // Sequencer state and register file ports
  // ---------------------------------------------------------------
  csd_state_e state_r, state_nxt;
  logic [15:0] tx_r, tx_nxt;
  logic standby_r, standby_nxt;
  logic [4:0] mr_addr_r, mr_addr_nxt;
  logic [7:0] mr_left_r, mr_left_nxt;
  logic [7:0] extra_r, extra_nxt;
  logic clr;
  logic we0, we1;
  logic [4:0] wa0, wa1;
  logic [7:0] wd0, wd1;
  logic [5:0] ra0, ra1;
  logic [7:0] rd0, rd1;

  csd_regfile u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(clr),
    .fault_i(fault_status_i),
    .we0_i(we0),
    .waddr0_i(wa0),
    .wdata0_i(wd0),
    .we1_i(we1),
    .waddr1_i(wa1),
    .wdata1_i(wd1),
    .raddr0_i(ra0),
    .raddr1_i(ra1),
    .rdata0_o(rd0),
    .rdata1_o(rd1)
  );

  // ---------------------------------------------------------------
  // Command fields
  // ---------------------------------------------------------------
  logic [15:0] cmd;
  logic [2:0] op;
  logic [4:0] addr;
  logic [7:0] lo;
  logic [8:0] cnt;
  logic [8:0] pos;
  logic mw_ok;

  assign cmd = fr.first_word;
  assign op = cmd[OP_MSB:OP_LSB];
  assign addr = cmd[ADDR_MSB:ADDR_LSB];
  assign lo = cmd[7:0];
  assign cnt = {1'b0, lo} + CNT_ONE;
  assign pos = {fr.data_idx, 1'b0};
  assign mw_ok = (state_r == ST_OPEN) && (mr_left_r == IDX_ZERO) && (op == OP_MULTI);

  // ---------------------------------------------------------------
  // Read addressing: multi-read drain or current command
  // ---------------------------------------------------------------
  always_comb begin
    if (mr_left_r != IDX_ZERO) begin
      ra0 = {1'b0, mr_addr_r};
    end else begin
      ra0 = {1'b0, addr};
    end
    ra1 = ra0 + 6'h01;
  end

  // ---------------------------------------------------------------
  // Multi-write data words, two registers each
  // ---------------------------------------------------------------
  // Full-width sums so a long count cannot wrap back into low registers
  logic [8:0] mw_s0, mw_s1;
  logic [5:0] mw_a0, mw_a1;
  assign mw_s0 = {4'h0, addr} + pos;
  assign mw_s1 = mw_s0 + CNT_ONE;
  assign mw_a0 = mw_s0[5:0];
  assign mw_a1 = mw_s1[5:0];

  always_comb begin
    we0 = 1'b0;
    we1 = 1'b0;
    wa0 = mw_a0[4:0];
    wa1 = mw_a1[4:0];
    wd0 = fr.data_word[15:8];
    wd1 = fr.data_word[7:0];
    if (fr.data_valid && mw_ok) begin
      // Data past the register space or past the count is dropped
      we0 = (pos < cnt) && (mw_s0[8:6] == 3'h0) && csd_in_range(mw_a0);
      we1 = ((pos + CNT_ONE) < cnt) && (mw_s1[8:6] == 3'h0) && csd_in_range(mw_a1);
    end else if (fr.frame_done && state_r == ST_OPEN && mr_left_r == IDX_ZERO && op == OP_WRITE) begin
      we0 = 1'b1;
      wa0 = addr;
      wd0 = lo;
    end
  end

  // ---------------------------------------------------------------
  // Command execution at frame end
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    tx_nxt = tx_r;
    standby_nxt = standby_r;
    mr_addr_nxt = mr_addr_r;
    mr_left_nxt = mr_left_r;
    extra_nxt = extra_r;
    clr = 1'b0;
    if (fr.first_valid && op == OP_MULTI && state_r == ST_OPEN) begin
      // Extra words the host appends to finish a multi write
      extra_nxt = 8'(cnt[8:1] + {7'h00, cnt[0]});
    end
    if (frame_start_i) begin
      extra_nxt = IDX_ZERO;
    end
    if (fr.frame_done) begin
      tx_nxt = csd_reg_resp(FAULT_ADDR, fault_status_i);
      if (mr_left_r != IDX_ZERO) begin
        tx_nxt = {rd0, rd1};
        // Park past the top so the drain cannot wrap back to 00h
        if (csd_in_range({1'b0, mr_addr_r})) begin
          mr_addr_nxt = mr_addr_r + 5'h02;
        end
        mr_left_nxt = mr_left_r - 8'h01;
      end else if (state_r == ST_POR) begin
        tx_nxt = {READY_HI, DEV_ID};
        if (cmd == CMD_UNLOCK) begin
          state_nxt = ST_OPEN;
          tx_nxt = CMD_UNLOCK;
        end
      end else if (cmd == CMD_NULL) begin
        // Null never echoes; standby keeps showing the ready word
        // Fault status is read live; the array slot at 02h is never shown
        tx_nxt = standby_r ? {READY_HI, DEV_ID} : csd_reg_resp(FAULT_ADDR, fault_status_i);
      end else if (cmd == CMD_UNLOCK) begin
        state_nxt = ST_OPEN;
        tx_nxt = CMD_UNLOCK;
      end else if (op == OP_READ) begin
        if (lo == IDX_ZERO) begin
          tx_nxt = csd_reg_resp(addr, rd0);
        end else begin
          tx_nxt = {OP_MULTI, addr, lo};
          mr_addr_nxt = addr;
          mr_left_nxt = 8'(cnt[8:1] + {7'h00, cnt[0]});
        end
      end else if (state_r == ST_LOCKED) begin
        tx_nxt = csd_reg_resp(FAULT_ADDR, fault_status_i);
      end else if (cmd == CMD_RESET) begin
        clr = 1'b1;
        standby_nxt = 1'b0;
        state_nxt = ST_POR;
        tx_nxt = {READY_HI, DEV_ID};
      end else if (cmd == CMD_STANDBY) begin
        standby_nxt = 1'b1;
        tx_nxt = cmd;
      end else if (cmd == CMD_WAKEUP) begin
        standby_nxt = 1'b0;
        tx_nxt = cmd;
      end else if (cmd == CMD_LOCK) begin
        state_nxt = ST_LOCKED;
        tx_nxt = cmd;
      end else if (op == OP_WRITE) begin
        // Shows what the register will hold; read-only and absent slots differ
        if (!csd_in_range({1'b0, addr})) begin
          tx_nxt = csd_reg_resp(addr, 8'h00);
        end else if (addr == FAULT_ADDR) begin
          tx_nxt = csd_reg_resp(addr, fault_status_i);
        end else begin
          tx_nxt = csd_reg_resp(addr, lo);
        end
      end else if (op == OP_MULTI) begin
        tx_nxt = {OP_WRITE, addr, lo};
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_POR;
      tx_r <= {READY_HI, 8'h00};
      standby_r <= 1'b0;
      mr_addr_r <= 5'h00;
      mr_left_r <= IDX_ZERO;
      extra_r <= IDX_ZERO;
    end else begin
      state_r <= state_nxt;
      tx_r <= tx_nxt;
      standby_r <= standby_nxt;
      mr_addr_r <= mr_addr_nxt;
      mr_left_r <= mr_left_nxt;
      extra_r <= extra_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  logic [31:0] tx_out_r, tx_out_nxt;
  logic one_r, one_nxt;
  logic lock_r, lock_nxt;
  logic sb_r, sb_nxt;
  logic id_seen_r, id_seen_nxt;
  logic [7:0] ext_r, ext_nxt;

  always_comb begin
    // Reset word cannot carry the identifier, so patch it in once
    if (!id_seen_r) begin
      tx_out_nxt = {READY_HI, DEV_ID, LSB_PAD};
    end else begin
      tx_out_nxt = {tx_r, LSB_PAD};
    end
    id_seen_nxt = id_seen_r || fr.frame_done;
    one_nxt = (state_r == ST_POR) || standby_r;
    // Power-up counts as locked: only unlock is taken there
    lock_nxt = (state_r != ST_OPEN);
    sb_nxt = standby_r;
    ext_nxt = extra_r;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_out_r <= 32'h0000_0000;
      one_r <= 1'b1;
      lock_r <= 1'b0;
      sb_r <= 1'b0;
      ext_r <= IDX_ZERO;
      id_seen_r <= 1'b0;
    end else begin
      tx_out_r <= tx_out_nxt;
      one_r <= one_nxt;
      lock_r <= lock_nxt;
      sb_r <= sb_nxt;
      ext_r <= ext_nxt;
      id_seen_r <= id_seen_nxt;
    end
  end

  assign tx_status_o = tx_out_r;
  assign one_word_frame_o = one_r;
  assign extra_words_o = ext_r;
  assign standby_o = sb_r;
  assign locked_o = lock_r;

endmodule : csd_decoder

//--- csd_decoder_chk.sv
`timescale 1ns/1ns
module csd_decoder_chk
  import csd_pkg::*;
#(
  parameter logic [7:0] DEV_ID = 8'h5A
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic frame_start_i,
  input wire logic frame_end_i,
  input wire logic rx_valid_i,
  input wire logic [15:0] rx_word_i,
  input wire logic [7:0] fault_status_i,
  input wire logic [31:0] tx_status_o,
  input wire logic one_word_frame_o,
  input wire logic [7:0] extra_words_o,
  input wire logic standby_o,
  input wire logic locked_o
);
  // ---------------------------------------------------------------
  // Command capture and read-drain tracking
  // ---------------------------------------------------------------
  logic [15:0] cmd_r;
  logic [15:0] cmd_nxt;
  logic first_r;
  logic first_nxt;
  logic [7:0] drn_r;
  logic [7:0] drn_nxt;
  logic idle_w;
  logic [15:0] flt_w;
  assign idle_w = (drn_r == 8'h00);
  assign flt_w = {OP_READ, FAULT_ADDR, fault_status_i};
  always_comb begin
    cmd_nxt = cmd_r;
    first_nxt = first_r || frame_start_i;
    drn_nxt = drn_r;
    if (rx_valid_i && first_r) begin
      cmd_nxt = rx_word_i;
      first_nxt = 1'b0;
    end
    // Data words still owed swallow the frame's command
    if (frame_end_i && !idle_w) begin
      drn_nxt = drn_r - 8'h01;
    end else if (frame_end_i && cmd_r[15:13] == OP_READ && cmd_r[7:0] != 8'h00 && !(locked_o && one_word_frame_o)) begin
      drn_nxt = 8'(({1'b0, cmd_r[7:0]} + 9'h002) >> 1);
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_r <= 16'hFFFF;
      first_r <= 1'b0;
      drn_r <= 8'h00;
    end else begin
      cmd_r <= cmd_nxt;
      first_r <= first_nxt;
      drn_r <= drn_nxt;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_LSB_ZERO: assert property (tx_status_o[15:0] == LSB_PAD)
    else $error("status low half not zero");
  AST_ANSWER_TIME: assert property ($changed(tx_status_o) |-> $past(frame_end_i, 2) || $past(rst_i, 2))
    else $error("status changed outside answer slot");
  AST_READY_WORD: assert property ($changed(tx_status_o) && locked_o && one_word_frame_o |->
    tx_status_o[31:16] == {READY_HI, DEV_ID}) else $error("power-up state sent non-ready word");
  AST_ECHO: assert property (frame_end_i && idle_w && !locked_o && (cmd_r == CMD_WAKEUP || cmd_r == CMD_STANDBY)
    |-> ##3 tx_status_o[31:16] == cmd_r) else $error("command not echoed");
  AST_LOCK_ENTER: assert property (frame_end_i && idle_w && !locked_o && cmd_r == CMD_LOCK
    |-> ##2 locked_o ##1 tx_status_o[31:16] == CMD_LOCK) else $error("lock not entered");
  AST_UNLOCK: assert property (frame_end_i && idle_w && cmd_r == CMD_UNLOCK
    |-> ##2 !locked_o ##1 tx_status_o[31:16] == CMD_UNLOCK) else $error("unlock not taken");
  AST_NULL_FAULT: assert property (frame_end_i && idle_w && !one_word_frame_o && cmd_r == CMD_NULL
    |-> ##3 tx_status_o[31:16] == flt_w) else $error("null did not return fault register");
  AST_LOCKED_IGNORE: assert property (frame_end_i && idle_w && locked_o && !one_word_frame_o &&
    cmd_r[15:13] == OP_WRITE |-> ##3 tx_status_o[31:16] == flt_w) else $error("write acted while locked");
  AST_SRESET: assert property (frame_end_i && idle_w && !locked_o && cmd_r == CMD_RESET
    |-> ##2 (locked_o && one_word_frame_o) ##1 tx_status_o[31:16] == {READY_HI, DEV_ID})
    else $error("software reset did not end in ready state");
  AST_WRITE_RESP: assert property (frame_end_i && idle_w && !locked_o && cmd_r[15:13] == OP_WRITE &&
    cmd_r[12:8] != FAULT_ADDR && cmd_r[12:8] <= REG_LAST |-> ##3 tx_status_o[31:16] == {OP_READ, cmd_r[12:0]})
    else $error("write response wrong");
endmodule : csd_decoder_chk

bind csd_decoder csd_decoder_chk #(.DEV_ID(DEV_ID)) u_csd_decoder_chk (
  .clk_i(clk_i), .rst_i(rst_i), .frame_start_i(frame_start_i), .frame_end_i(frame_end_i),
  .rx_valid_i(rx_valid_i), .rx_word_i(rx_word_i), .fault_status_i(fault_status_i),
  .tx_status_o(tx_status_o), .one_word_frame_o(one_word_frame_o), .extra_words_o(extra_words_o),
  .standby_o(standby_o), .locked_o(locked_o)
);

//--- csd_frame_capture.sv
`timescale 1ns/1ns
module csd_frame_capture
  import csd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic frame_start_i,
  input wire logic frame_end_i,
  input wire logic rx_valid_i,
  input wire logic [15:0] rx_word_i,
  csd_frame_if.cap fr
);

  // ---------------------------------------------------------------
  // Word counter and first-word latch
  // ---------------------------------------------------------------
  logic [7:0] cnt_r, cnt_nxt;
  logic [15:0] first_r, first_nxt;
  logic seen_r, seen_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    first_nxt = first_r;
    seen_nxt = seen_r;
    if (frame_start_i) begin
      cnt_nxt = IDX_ZERO;
      seen_nxt = 1'b0;
    end else if (rx_valid_i) begin
      // Saturate so a runaway frame cannot alias back to word zero
      if (cnt_r != 8'hFF) begin
        cnt_nxt = cnt_r + 8'h01;
      end
      if (!seen_r) begin
        first_nxt = rx_word_i;
        seen_nxt = 1'b1;
      end
    end else if (frame_end_i) begin
      seen_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= IDX_ZERO;
      first_r <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      first_r <= first_nxt;
      seen_r <= seen_nxt;
    end
  end

  assign fr.first_valid = seen_r;
  assign fr.first_word = first_r;
  assign fr.data_valid = rx_valid_i && seen_r && !frame_start_i;
  assign fr.data_word = rx_word_i;
  assign fr.data_idx = cnt_r - 8'h01;
  // A frame with no word carries no command
  assign fr.frame_done = frame_end_i && seen_r;

endmodule : csd_frame_capture

//--- csd_frame_if.sv
`timescale 1ns/1ns
interface csd_frame_if;
  logic first_valid;
  logic [15:0] first_word;
  logic data_valid;
  logic [15:0] data_word;
  logic [7:0] data_idx;
  logic frame_done;

  modport cap (
    output first_valid,
    output first_word,
    output data_valid,
    output data_word,
    output data_idx,
    output frame_done
  );
  modport dec (
    input first_valid,
    input first_word,
    input data_valid,
    input data_word,
    input data_idx,
    input frame_done
  );
endinterface : csd_frame_if

//--- csd_host_model.sv
`timescale 1ns/1ns
module csd_host_model (
  input wire logic clk_i,
  output logic frame_start_o,
  output logic frame_end_o,
  output logic rx_valid_o,
  output logic [15:0] rx_word_o
);
  // ---------------------------------------------------------------
  // Host frame driver
  // ---------------------------------------------------------------
  initial begin
    frame_start_o = 1'b0;
    frame_end_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_word_o = 16'h0000;
  end
  task automatic send_frame(input logic [15:0] cmd, input logic [15:0] dat, input bit more);
    @(negedge clk_i);
    frame_start_o = 1'b1;
    @(negedge clk_i);
    frame_start_o = 1'b0;
    rx_valid_o = 1'b1;
    rx_word_o = cmd;
    @(negedge clk_i);
    if (more) begin
      // Valid stays up: the data word follows the command directly
      rx_word_o = dat;
      @(negedge clk_i);
    end
    rx_valid_o = 1'b0;
    // Released word shows inverse so stale data never passes
    rx_word_o = ~rx_word_o;
    frame_end_o = 1'b1;
    @(negedge clk_i);
    frame_end_o = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : send_frame
endmodule : csd_host_model

//--- csd_pkg.sv
package csd_pkg;

  // ---------------------------------------------------------------
  // Command codes and opcodes
  // ---------------------------------------------------------------
  localparam logic [15:0] CMD_NULL = 16'h0000;
  localparam logic [15:0] CMD_RESET = 16'h0011;
  localparam logic [15:0] CMD_STANDBY = 16'h0022;
  localparam logic [15:0] CMD_WAKEUP = 16'h0033;
  localparam logic [15:0] CMD_LOCK = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK = 16'h0655;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_MULTI = 3'h3;

  // ---------------------------------------------------------------
  // Field layout, register space, reset values
  // ---------------------------------------------------------------
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 13;
  localparam int ADDR_MSB = 12;
  localparam int ADDR_LSB = 8;
  localparam logic [7:0] READY_HI = 8'hFF;
  localparam logic [4:0] FAULT_ADDR = 5'h02;
  localparam logic [4:0] REG_LAST = 5'h14;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] LSB_PAD = 16'h0000;
  localparam logic [7:0] IDX_ZERO = 8'h00;
  localparam logic [8:0] CNT_ONE = 9'h001;
  localparam logic [8:0] CNT_TWO = 9'h002;

  typedef enum logic [1:0] {
    ST_POR,
    ST_OPEN,
    ST_LOCKED
  } csd_state_e;

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] csd_reg_resp(input logic [4:0] addr, input logic [7:0] data);
    csd_reg_resp = {OP_READ, addr, data};
  endfunction : csd_reg_resp

  function automatic logic csd_in_range(input logic [5:0] addr);
    csd_in_range = (addr <= {1'b0, REG_LAST});
  endfunction : csd_in_range

endpackage : csd_pkg

//--- csd_regfile.sv
`timescale 1ns/1ns
module csd_regfile
  import csd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic [7:0] fault_i,
  input wire logic we0_i,
  input wire logic [4:0] waddr0_i,
  input wire logic [7:0] wdata0_i,
  input wire logic we1_i,
  input wire logic [4:0] waddr1_i,
  input wire logic [7:0] wdata1_i,
  input wire logic [5:0] raddr0_i,
  input wire logic [5:0] raddr1_i,
  output logic [7:0] rdata0_o,
  output logic [7:0] rdata1_o
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] mem_r [0:REG_LAST];
  logic [7:0] mem_nxt [0:REG_LAST];

  function automatic logic [7:0] rd(input logic [5:0] a, input logic [7:0] flt, input logic [7:0] v);
    if (!csd_in_range(a)) begin
      rd = 8'h00;
    end else if (a[4:0] == FAULT_ADDR) begin
      rd = flt;
    end else begin
      rd = v;
    end
  endfunction : rd

  always_comb begin
    for (int i = 0; i <= int'(REG_LAST); i++) begin
      if (clr_i) begin
        mem_nxt[i] = REG_RST;
      end else if (we0_i && waddr0_i == 5'(i)) begin
        mem_nxt[i] = wdata0_i;
      end else if (we1_i && waddr1_i == 5'(i)) begin
        mem_nxt[i] = wdata1_i;
      end else begin
        mem_nxt[i] = mem_r[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i <= int'(REG_LAST); i++) begin
        mem_r[i] <= REG_RST;
      end
    end else begin
      for (int i = 0; i <= int'(REG_LAST); i++) begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

  // Out-of-range reads index a clamped slot and are then forced to zero
  assign rdata0_o = rd(raddr0_i, fault_i, mem_r[csd_in_range(raddr0_i) ? raddr0_i[4:0] : 5'h00]);
  assign rdata1_o = rd(raddr1_i, fault_i, mem_r[csd_in_range(raddr1_i) ? raddr1_i[4:0] : 5'h00]);

endmodule : csd_regfile

//--- tb_csd_decoder.sv
`timescale 1ns/1ns
module tb_csd_decoder
  import csd_pkg::*;
;
  localparam logic [7:0] ID = 8'h5A; // Arbitrary identifier
  localparam logic [15:0] RDY = {READY_HI, ID};
  localparam logic [15:0] FLT = {OP_READ, FAULT_ADDR, 8'h3C};
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] exp;
    logic lk;
  } csd_row_s;
  logic clk_i;
  logic rst_i;
  logic fs;
  logic fe;
  logic rv;
  logic [15:0] rw;
  logic [7:0] fault;
  logic [31:0] tx;
  logic [7:0] ext;
  logic one_w;
  logic sb;
  logic lk;
  int num_errors;
  int cmp_count;
  csd_row_s rows [15] = '{
    '{16'h0655, 16'h0655, 1'b0},
    '{16'h0000, FLT, 1'b0},
    '{16'h4155, 16'h2155, 1'b0},
    '{16'h2100, 16'h2155, 1'b0},
    '{16'h5477, 16'h3477, 1'b0},
    '{16'h42AA, FLT, 1'b0},
    '{16'hE000, FLT, 1'b0},
    '{16'h0022, 16'h0022, 1'b0},
    '{16'h0000, RDY, 1'b0},
    '{16'h0033, 16'h0033, 1'b0},
    '{16'h0555, 16'h0555, 1'b1},
    '{16'h4199, FLT, 1'b1},
    '{16'h0011, FLT, 1'b1},
    '{16'h2100, 16'h2155, 1'b1},
    '{16'h0655, 16'h0655, 1'b0}
  };
  csd_decoder #(.DEV_ID(ID)) u_csd_decoder (
    .clk_i(clk_i), .rst_i(rst_i), .frame_start_i(fs), .frame_end_i(fe), .rx_valid_i(rv),
    .rx_word_i(rw), .fault_status_i(fault), .tx_status_o(tx), .one_word_frame_o(one_w),
    .extra_words_o(ext), .standby_o(sb), .locked_o(lk)
  );
  csd_host_model u_csd_host_model (
    .clk_i(clk_i), .frame_start_o(fs), .frame_end_o(fe), .rx_valid_o(rv), .rx_word_o(rw)
  );
  // ---------------------------------------------------------------
  // Checks and frames
  // ---------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic chk_flag(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_flag
  task automatic resp(input logic [15:0] c, input logic [15:0] e, input logic [15:0] d = 16'h0000, input bit m = 0);
    u_csd_host_model.send_frame(c, d, m);
    chk_word("status", e, tx[31:16]);
    chk_word("pad", LSB_PAD, tx[15:0]);
  endtask : resp
  task automatic summarize;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Guard against a hung sequence
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  initial begin
    rst_i = 1'b1;
    fault = 8'h3C;
    num_errors = 0;
    cmp_count = 0;
    repeat (12) @(negedge clk_i);
    chk_flag("reset one word", 1'b1, one_w);
    rst_i = 1'b0;
    @(negedge clk_i);
    chk_word("power-up", RDY, tx[31:16]);
    chk_flag("power-up lock", 1'b1, lk);
    resp(16'h4155, RDY);
    foreach (rows[i]) begin
      resp(rows[i].cmd, rows[i].exp);
      chk_flag("locked", rows[i].lk, lk);
    end
    resp(16'h0022, 16'h0022);
    chk_flag("standby", 1'b1, sb);
    chk_flag("standby one word", 1'b1, one_w);
    resp(16'h0033, 16'h0033);
    chk_flag("standby", 1'b0, sb);
    // Multi write 13h..14h, then read 13h..15h across the top
    resp(16'h7301, 16'h5301, 16'hABCD, 1);
    chk_word("extra words", 16'h0001, {8'h00, ext});
    resp(16'h3302, 16'h7302);
    resp(16'h4111, 16'hABCD);
    resp(16'h0555, 16'h0000);
    chk_flag("drain lock", 1'b0, lk);
    resp(16'h2100, 16'h2155);
    // Read from 1Fh must stay zero and never wrap to 00h
    resp(16'h3F04, 16'h7F04);
    repeat (3) resp(16'h0000, 16'h0000);
    resp(16'h0011, RDY);
    chk_flag("reset one word", 1'b1, one_w);
    resp(16'h2100, RDY);
    resp(16'h0655, 16'h0655);
    resp(16'h2100, 16'h2100);
    @(negedge clk_i);
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    chk_word("re-reset", RDY, tx[31:16]);
    summarize();
  end
endmodule : tb_csd_decoder
